// File: core/pss_status_summary.sv
// What this block does
// - bit 13 latches high on any receive error and is cleared only by a read of register 15h.
// - bit 12 latches high on the inverted polarity flag and is cleared only by a read of the ten meg status register.
// - bit 11 latches high on any false carrier and is cleared only by a read of register 14h.
// - bit 10 is latch-low qualified signal detect, raw detect ANDed with lock when 16h bit 8 is set.
// - bit 9 is the descrambler lock as a latch-low bit.
// - bit 8 latches the page received flag and only a read of 06h clears it.
// - bit 7 shows a pending internal interrupt, cleared by a read of 12h.
// - bit 6 latches remote fault from the partner, cleared by a read of 01h or by reset.
// - bit 5 latches jabber in 10 Mb/s operation and a read of this register leaves it alone.
// - bit 4 reads 1 once auto-negotiation has completed.
// - bit 3 reads 1 while loopback is enabled.
//
// The address-and-strobe port was left to the implementer.
module pss_status_summary
    import pss_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // management register port
    input wire pss_req_type req,
    output logic [15:0] rdata,
    // status sources
    input wire pss_src_type src,
    // interrupt
    output logic irq
);

    logic rd_basic_status;
    logic rd_autoneg_expansion;
    logic rd_summary;
    logic rd_int_status;
    logic rd_false_carrier;
    logic rd_rx_error;
    logic rd_ten_meg;
    logic qualified_sd;
    logic qualify_reg;
    logic autoneg_done_reg;
    logic loopback_reg;
    logic sd_prev_reg;
    logic [15:0] phy_status_summary;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [4:0] evt_status_reg;
    logic [4:0] evt_status_next;
    logic [4:0] evt_enable_reg;
    logic [4:0] evt_raise;
    logic irq_reg;
    logic b_rx_err;
    logic b_polarity;
    logic b_false_carrier;
    logic b_sd;
    logic b_lock;
    logic b_page;
    logic b_int;
    logic b_remote_fault;
    logic b_jabber;

    // clearing reads, decoded once
    assign rd_basic_status = req.rd && (req.addr == PSS_BASIC_STATUS_ADDR);
    assign rd_autoneg_expansion = req.rd && (req.addr == PSS_AUTONEG_EXPANSION_ADDR);
    assign rd_summary = req.rd && (req.addr == PSS_PHY_STATUS_SUMMARY_ADDR);
    assign rd_int_status = req.rd && (req.addr == PSS_INTERRUPT_STATUS_EVENT_CONTROL_ADDR);
    assign rd_false_carrier = req.rd && (req.addr == PSS_FALSE_CARRIER_COUNTER_ADDR);
    assign rd_rx_error = req.rd && (req.addr == PSS_RECEIVE_ERROR_COUNTER_ADDR);
    assign rd_ten_meg = req.rd && (req.addr == PSS_TEN_MEG_STATUS_CONTROL_ADDR);

    // signal detect as the link monitor sees it
    assign qualified_sd = src.raw_signal_detect && (!qualify_reg || src.descrambler_lock);

    // latched summary bits
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_rx_err (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.rx_error_event),
        .clr_in(rd_rx_error),
        .q(b_rx_err)
    );

    pss_latch_bit #(.LATCH_LOW(1'b0)) u_polarity (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.polarity_inverted),
        .clr_in(rd_ten_meg),
        .q(b_polarity)
    );

    pss_latch_bit #(.LATCH_LOW(1'b0)) u_false_carrier (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.false_carrier_event),
        .clr_in(rd_false_carrier),
        .q(b_false_carrier)
    );

    pss_latch_bit #(.LATCH_LOW(1'b1)) u_sd (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(qualified_sd),
        .clr_in(rd_summary),
        .q(b_sd)
    );

    pss_latch_bit #(.LATCH_LOW(1'b1)) u_lock (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.descrambler_lock),
        .clr_in(rd_summary),
        .q(b_lock)
    );

    pss_latch_bit #(.LATCH_LOW(1'b0)) u_page (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.page_received_event),
        .clr_in(rd_autoneg_expansion),
        .q(b_page)
    );

    pss_latch_bit #(.LATCH_LOW(1'b0)) u_int (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.interrupt_event),
        .clr_in(rd_int_status),
        .q(b_int)
    );

    pss_latch_bit #(.LATCH_LOW(1'b0)) u_remote_fault (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.remote_fault_event),
        .clr_in(rd_basic_status),
        .q(b_remote_fault)
    );

    // jabber only counts in 10 Mb/s; the basic status read clears it like its twin
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_jabber (
        .sys_clk(sys_clk),
        .rst(rst),
        .src_in(src.jabber_event && src.speed_10),
        .clr_in(rd_basic_status),
        .q(b_jabber)
    );

    // plain level copies, registered so reads see a steady value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            autoneg_done_reg <= 1'b0;
            loopback_reg <= 1'b0;
        end else begin
            autoneg_done_reg <= src.autoneg_complete;
            loopback_reg <= src.loopback_enabled;
        end
    end

    // assembled summary; upper, lower and unused bits read as zero
    always_comb begin
        phy_status_summary = PSS_STATUS_RESET;
        phy_status_summary[PSS_RX_ERR_BIT] = b_rx_err;
        phy_status_summary[PSS_POLARITY_BIT] = b_polarity;
        phy_status_summary[PSS_FALSE_CARRIER_BIT] = b_false_carrier;
        phy_status_summary[PSS_SIGNAL_DETECT_BIT] = b_sd;
        phy_status_summary[PSS_DESCR_LOCK_BIT] = b_lock;
        phy_status_summary[PSS_PAGE_RCVD_BIT] = b_page;
        phy_status_summary[PSS_INT_PENDING_BIT] = b_int;
        phy_status_summary[PSS_REMOTE_FAULT_BIT] = b_remote_fault;
        phy_status_summary[PSS_JABBER_BIT] = b_jabber;
        phy_status_summary[PSS_AUTONEG_DONE_BIT] = autoneg_done_reg;
        phy_status_summary[PSS_LOOPBACK_BIT] = loopback_reg;
    end

    // qualify enable: the only software write that steers the summary
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            qualify_reg <= PSS_QUALIFY_RESET;
        end else if (req.wr && req.addr == PSS_PCS_CONFIG_ADDR) begin
            qualify_reg <= req.wdata[PSS_SD_QUALIFY_BIT];
        end
    end

    // interrupt events; rising edges of latched bits would miss repeats, so raw pulses are used, and lost detect is the falling edge of the qualified level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sd_prev_reg <= 1'b0;
        end else begin
            sd_prev_reg <= qualified_sd;
        end
    end

    always_comb begin
        evt_raise = PSS_EVT_RESET;
        evt_raise[PSS_EVT_RX_ERR] = src.rx_error_event;
        evt_raise[PSS_EVT_FALSE_CARRIER] = src.false_carrier_event;
        evt_raise[PSS_EVT_PAGE_RCVD] = src.page_received_event;
        evt_raise[PSS_EVT_REMOTE_FAULT] = src.remote_fault_event;
        evt_raise[PSS_EVT_SD_LOST] = sd_prev_reg && !qualified_sd;
    end

    // write-one-to-clear; a new event in the clearing cycle survives
    always_comb begin
        evt_status_next = evt_status_reg;
        if (req.wr && req.addr == PSS_EVT_CLEAR_ADDR) begin
            evt_status_next = evt_status_next & ~req.wdata[4:0];
        end
        evt_status_next = evt_status_next | evt_raise;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_status_reg <= PSS_EVT_RESET;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_enable_reg <= PSS_EVT_RESET;
        end else if (req.wr && req.addr == PSS_EVT_ENABLE_ADDR) begin
            evt_enable_reg <= req.wdata[4:0];
        end
    end

    // level interrupt, one cycle behind the status it reflects
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(evt_status_reg & evt_enable_reg);
        end
    end

    // read mux; the other registers named here live elsewhere and read as zero
    always_comb begin
        rdata_next = PSS_RDATA_RESET;
        case (req.addr)
            PSS_PHY_STATUS_SUMMARY_ADDR: begin
                rdata_next = phy_status_summary;
            end
            PSS_PCS_CONFIG_ADDR: begin
                rdata_next[PSS_SD_QUALIFY_BIT] = qualify_reg;
            end
            PSS_EVT_STATUS_ADDR: begin
                rdata_next[4:0] = evt_status_reg;
            end
            PSS_EVT_ENABLE_ADDR: begin
                rdata_next[4:0] = evt_enable_reg;
            end
            default: begin
                rdata_next = PSS_RDATA_RESET;
            end
        endcase
    end

    // data held only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= PSS_RDATA_RESET;
        end else if (req.rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= PSS_RDATA_RESET;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    sequence rx_err_seen_s;
        src.rx_error_event ##1 b_rx_err;
    endsequence

    rx_err_latch_a: assert property (
        rx_err_seen_s ##0 !rd_rx_error |=> b_rx_err
    ) else $error("receive error latch lost before its clearing read");

    rx_err_clear_a: assert property (
        rd_rx_error && !src.rx_error_event |=> !b_rx_err
    ) else $error("receive error latch not cleared by counter read");

    polarity_clear_a: assert property (
        $fell(b_polarity) |-> $past(rd_ten_meg)
    ) else $error("polarity bit dropped without a ten meg status read");

    false_carrier_a: assert property (
        src.false_carrier_event |=> b_false_carrier ##0 (b_false_carrier || $past(rd_false_carrier))
    ) else $error("false carrier latch missed an event");

    fc_clear_a: assert property (
        $fell(b_false_carrier) |-> $past(rd_false_carrier)
    ) else $error("false carrier latch cleared without counter read");

    sd_reload_a: assert property (
        rd_summary |=> b_sd == $past(src.raw_signal_detect && (!qualify_reg || src.descrambler_lock))
    ) else $error("signal detect not reloaded with qualified level");

    sd_hold_low_a: assert property (
        !b_sd && !rd_summary |=> !b_sd
    ) else $error("signal detect rose without a summary read");

    lock_low_a: assert property (
        !src.descrambler_lock |=> !b_lock
    ) else $error("descrambler lock did not latch low");

    page_clear_a: assert property (
        $fell(b_page) |-> $past(rd_autoneg_expansion)
    ) else $error("page received cleared by the wrong read");

    sequence int_wait_s;
        src.interrupt_event ##1 !rd_int_status [*2];
    endsequence

    int_pending_a: assert property (
        int_wait_s |=> b_int
    ) else $error("interrupt pending dropped before its status read");

    remote_fault_a: assert property (
        src.remote_fault_event |=> b_remote_fault
    ) else $error("remote fault not latched");

    rf_clear_a: assert property (
        $fell(b_remote_fault) |-> $past(rd_basic_status)
    ) else $error("remote fault cleared without basic status read");

    jabber_keep_a: assert property (
        b_jabber && rd_summary && !rd_basic_status |=> b_jabber
    ) else $error("summary read cleared jabber");

    jabber_gate_a: assert property (
        !b_jabber && src.jabber_event && !src.speed_10 |=> !b_jabber
    ) else $error("jabber set outside 10 Mb/s");

    autoneg_bit_a: assert property (
        ##1 phy_status_summary[PSS_AUTONEG_DONE_BIT] == $past(src.autoneg_complete)
    ) else $error("auto-negotiation complete bit wrong");

    loopback_bit_a: assert property (
        ##1 phy_status_summary[PSS_LOOPBACK_BIT] == $past(src.loopback_enabled)
    ) else $error("loopback bit wrong");

    reset_zero_a: assert property (
        $past(rst) |-> phy_status_summary == PSS_STATUS_RESET
    ) else $error("summary not zero after reset");

    fixed_zero_a: assert property (
        rd_summary |=> rdata[15:14] == 2'b00 && rdata[2:0] == 3'b000
    ) else $error("unowned summary bits read non-zero");

    irq_level_a: assert property (
        |(evt_raise & evt_enable_reg) && !(req.wr && req.addr == PSS_EVT_ENABLE_ADDR) |-> ##2 irq
    ) else $error("enabled event did not raise the interrupt output");

    rdata_one_cycle_a: assert property (
        !req.rd |=> rdata == PSS_RDATA_RESET
    ) else $error("read data outside the answer cycle");

endmodule : pss_status_summary

// File: core/pss_pkg.sv
package pss_pkg;

    // register port geometry
    localparam int PSS_ADDR_W = 5;
    localparam int PSS_DATA_W = 16;

    // register offsets on the management port
    localparam logic [4:0] PSS_BASIC_STATUS_ADDR = 5'h01;
    localparam logic [4:0] PSS_AUTONEG_EXPANSION_ADDR = 5'h06;
    localparam logic [4:0] PSS_PHY_STATUS_SUMMARY_ADDR = 5'h10;
    localparam logic [4:0] PSS_INTERRUPT_STATUS_EVENT_CONTROL_ADDR = 5'h12;
    localparam logic [4:0] PSS_FALSE_CARRIER_COUNTER_ADDR = 5'h14;
    localparam logic [4:0] PSS_RECEIVE_ERROR_COUNTER_ADDR = 5'h15;
    localparam logic [4:0] PSS_PCS_CONFIG_ADDR = 5'h16;
    localparam logic [4:0] PSS_TEN_MEG_STATUS_CONTROL_ADDR = 5'h1a;
    localparam logic [4:0] PSS_EVT_STATUS_ADDR = 5'h1d;
    localparam logic [4:0] PSS_EVT_ENABLE_ADDR = 5'h1e;
    localparam logic [4:0] PSS_EVT_CLEAR_ADDR = 5'h1f;

    // field positions inside the summary register
    localparam int PSS_RX_ERR_BIT = 13;
    localparam int PSS_POLARITY_BIT = 12;
    localparam int PSS_FALSE_CARRIER_BIT = 11;
    localparam int PSS_SIGNAL_DETECT_BIT = 10;
    localparam int PSS_DESCR_LOCK_BIT = 9;
    localparam int PSS_PAGE_RCVD_BIT = 8;
    localparam int PSS_INT_PENDING_BIT = 7;
    localparam int PSS_REMOTE_FAULT_BIT = 6;
    localparam int PSS_JABBER_BIT = 5;
    localparam int PSS_AUTONEG_DONE_BIT = 4;
    localparam int PSS_LOOPBACK_BIT = 3;

    // qualify enable inside the pcs config register
    localparam int PSS_SD_QUALIFY_BIT = 8;

    // event status layout
    localparam int PSS_EVT_W = 5;
    localparam int PSS_EVT_RX_ERR = 0;
    localparam int PSS_EVT_FALSE_CARRIER = 1;
    localparam int PSS_EVT_PAGE_RCVD = 2;
    localparam int PSS_EVT_REMOTE_FAULT = 3;
    localparam int PSS_EVT_SD_LOST = 4;

    // reset values
    localparam logic [15:0] PSS_STATUS_RESET = 16'h0000;
    localparam logic [15:0] PSS_RDATA_RESET = 16'h0000;
    localparam logic [4:0] PSS_EVT_RESET = 5'h00;
    localparam logic PSS_QUALIFY_RESET = 1'b0;

    // status sources from the rest of the transceiver
    typedef struct packed {
        logic rx_error_event;
        logic polarity_inverted;
        logic false_carrier_event;
        logic raw_signal_detect;
        logic descrambler_lock;
        logic page_received_event;
        logic interrupt_event;
        logic remote_fault_event;
        logic jabber_event;
        logic speed_10;
        logic autoneg_complete;
        logic loopback_enabled;
    } pss_src_type;

    // one management request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pss_req_type;

endpackage : pss_pkg

// File: core/pss_latch_bit.sv
// one latching status bit: latch high on an event, or latch low on a level
module pss_latch_bit
    import pss_pkg::*;
#(
    parameter bit LATCH_LOW = 1'b0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // source and clearing read
    input wire logic src_in,
    input wire logic clr_in,
    // latched value
    output logic q
);

    generate
        if (LATCH_LOW) begin : g_low
            // a clearing read reloads the live level; a drop sticks until then
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    q <= 1'b0;
                end else if (clr_in) begin
                    q <= src_in;
                end else if (!src_in) begin
                    q <= 1'b0;
                end
            end
        end else begin : g_high
            // set beats clear so an event landing on the read is kept
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    q <= 1'b0;
                end else if (src_in) begin
                    q <= 1'b1;
                end else if (clr_in) begin
                    q <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : pss_latch_bit

// File: tb/test_phy_status_summary_bits.sv
module test_phy_status_summary_bits;
    timeunit 1ns;
    timeprecision 1ps;
    import pss_pkg::*;

    // design ports
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    pss_req_type req = '0;
    pss_src_type src = '0;
    logic [15:0] rdata;
    logic irq;

    // bench bookkeeping
    int num_errors = 0;
    int checked = 0;
    integer seed = 78943;
    logic [11:0] lvl = 12'h187;

    // reference state, kept in step with the design at every rising edge
    logic armed = 1'b0;
    logic sum_rd = 1'b0;
    logic s_rx, s_pol, s_fc, s_sd, s_lk, s_pg, s_int, s_rf, s_jb, s_an, s_lb, qual, irq_e, live, sd_pv;
    logic [4:0] ev_st, ev_en;
    logic [15:0] exp_rd;

    // address table for the reset and random reads, and address and event tables for the clearing pairs
    logic [4:0] addr_tab [12] = '{5'h10, 5'h01, 5'h06, 5'h12, 5'h14, 5'h15, 5'h16, 5'h1a, 5'h1d, 5'h1e, 5'h1f, 5'h03};
    logic [4:0] clr_a [7] = '{5'h15, 5'h1a, 5'h14, 5'h06, 5'h12, 5'h01, 5'h01};
    logic [11:0] ev_v [7] = '{12'h800, 12'h400, 12'h200, 12'h040, 12'h020, 12'h010, 12'h008};

    pss_status_summary pss_status_summary_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(req),
        .rdata(rdata),
        .src(src),
        .irq(irq)
    );

    // 200 MHz
    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // summary word with the model's bits in their rule positions, spare bits zero
    function automatic logic [15:0] sum_word();
        return {2'b00, s_rx, s_pol, s_fc, s_sd, s_lk, s_pg, s_int, s_rf, s_jb, s_an, s_lb, 3'b000};
    endfunction : sum_word

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // one bus cycle: strobes last exactly one cycle because every cycle goes through here
    task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d,
                       input logic [11:0] s);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
        src <= pss_src_type'(s);
    endtask : bus

    // compare first, then advance; both sides see pre-edge values so no race
    always @(posedge sys_clk) begin
        if (armed) begin
            if (sum_rd) begin
                check("rx error bit", 16'(rdata[13]), 16'(exp_rd[13]));
                check("polarity bit", 16'(rdata[12]), 16'(exp_rd[12]));
                check("false carrier bit", 16'(rdata[11]), 16'(exp_rd[11]));
                check("signal detect bit", 16'(rdata[10]), 16'(exp_rd[10]));
                check("descrambler lock bit", 16'(rdata[9]), 16'(exp_rd[9]));
                check("page received bit", 16'(rdata[8]), 16'(exp_rd[8]));
                check("interrupt pending bit", 16'(rdata[7]), 16'(exp_rd[7]));
                check("remote fault bit", 16'(rdata[6]), 16'(exp_rd[6]));
                check("jabber bit", 16'(rdata[5]), 16'(exp_rd[5]));
                check("autoneg done bit", 16'(rdata[4]), 16'(exp_rd[4]));
                check("loopback bit", 16'(rdata[3]), 16'(exp_rd[3]));
                check("summary spare bits", rdata & 16'hc007, 16'h0000);
            end else begin
                check("read data", rdata, exp_rd);
            end
            check("irq", 16'(irq), 16'(irq_e));
        end
        if (rst) begin
            {s_rx, s_pol, s_fc, s_sd, s_lk, s_pg, s_int, s_rf, s_jb, s_an, s_lb, qual, irq_e, sd_pv} = '0;
            ev_st = '0;
            ev_en = '0;
            exp_rd = '0;
            sum_rd = 1'b0;
            armed = 1'b1;
        end else begin
            sum_rd = req.rd && req.addr == 5'h10;
            exp_rd = '0;
            if (req.rd) begin
                case (req.addr)
                    5'h10: exp_rd = sum_word();
                    5'h16: exp_rd = {7'h00, qual, 8'h00};
                    // all five event bits, the lost-detect one included
                    5'h1d: exp_rd = {11'h000, ev_st};
                    5'h1e: exp_rd = {11'h000, ev_en};
                    default: exp_rd = '0;
                endcase
            end
            irq_e = |(ev_st & ev_en);
            live = src.raw_signal_detect & (qual ? src.descrambler_lock : 1'b1);
            s_sd = sum_rd ? live : (s_sd & live);
            s_lk = sum_rd ? src.descrambler_lock : (s_lk & src.descrambler_lock);
            s_rx = src.rx_error_event | (s_rx & !(req.rd && req.addr == 5'h15));
            s_pol = src.polarity_inverted | (s_pol & !(req.rd && req.addr == 5'h1a));
            s_fc = src.false_carrier_event | (s_fc & !(req.rd && req.addr == 5'h14));
            s_pg = src.page_received_event | (s_pg & !(req.rd && req.addr == 5'h06));
            s_int = src.interrupt_event | (s_int & !(req.rd && req.addr == 5'h12));
            s_rf = src.remote_fault_event | (s_rf & !(req.rd && req.addr == 5'h01));
            s_jb = (src.jabber_event & src.speed_10) | (s_jb & !(req.rd && req.addr == 5'h01));
            s_an = src.autoneg_complete;
            s_lb = src.loopback_enabled;
            // lost detect: the qualified level was high one edge ago and is low now
            ev_st = {sd_pv & !live, src.remote_fault_event, src.page_received_event, src.false_carrier_event,
                     src.rx_error_event} | (ev_st & ~((req.wr && req.addr == 5'h1f) ? req.wdata[4:0] : 5'h00));
            sd_pv = live;
            if (req.wr && req.addr == 5'h1e) ev_en = req.wdata[4:0];
            if (req.wr && req.addr == 5'h16) qual = req.wdata[8];
        end
    end

    // a hang ends the run through the same closing task
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        int i;
        logic [31:0] k;
        logic [11:0] flip;
        logic [11:0] ev;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values of every mapped and one unmapped address
        for (i = 0; i < 12; i++) bus(1'b0, 1'b1, addr_tab[i], 16'h0000, 12'h000);
        $display("test reset values done");
        // each event beside its own clearing read: the set has to win, a lone read then clears
        for (i = 0; i < 7; i++) begin
            bus(1'b0, 1'b1, clr_a[i], 16'h0000, lvl | ev_v[i]);
            bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
            bus(1'b1, 1'b0, 5'h10, 16'hffff, lvl);
            bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
            bus(1'b0, 1'b1, clr_a[i], 16'h0000, lvl);
            bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        end
        $display("test set versus clear done");
        // latch-low: a one-cycle dip of lock with qualify on must stick until the summary is read
        bus(1'b1, 1'b0, 5'h16, 16'h0100, lvl);
        bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl & 12'hf7f);
        bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl & 12'hf7f);
        bus(1'b1, 1'b0, 5'h16, 16'h0000, lvl);
        bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        bus(1'b0, 1'b1, 5'h10, 16'h0000, lvl);
        $display("test latch low done");
        // interrupt: raise, mask, unmask, clear
        bus(1'b1, 1'b0, 5'h1e, 16'h000f, lvl);
        bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl | 12'h800);
        for (i = 0; i < 3; i++) bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl);
        bus(1'b1, 1'b0, 5'h1e, 16'h0000, lvl);
        for (i = 0; i < 3; i++) bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl);
        bus(1'b1, 1'b0, 5'h1e, 16'h000f, lvl);
        bus(1'b0, 1'b1, 5'h1d, 16'h0000, lvl);
        bus(1'b1, 1'b0, 5'h1f, 16'h001f, lvl);
        for (i = 0; i < 3; i++) bus(1'b0, 1'b1, 5'h1d, 16'h0000, lvl);
        $display("test interrupt done");
        // random traffic; levels drift slowly so latch-low bits see both states
        for (i = 0; i < 4000; i++) begin
            k = $random(seed);
            flip = $random(seed) & $random(seed) & $random(seed) & $random(seed) & 12'h187;
            ev = $random(seed) & $random(seed) & $random(seed) & 12'he78;
            lvl = (lvl ^ flip) & 12'h187;
            // any enable bit may be set; lost-detect events come from the drifting levels
            bus(k[1:0] == 2'd2, k[0], addr_tab[k[7:4] % 12], 16'($random(seed)), lvl | ev);
        end
        bus(1'b0, 1'b0, 5'h00, 16'h0000, lvl);
        repeat (3) @(posedge sys_clk);
        $display("test random traffic done");
        end_sim();
    end

endmodule : test_phy_status_summary_bits
